/* File: clock_cfg_pkg.sv */
package clock_cfg_pkg;
   // Register addresses on the processor interface
   localparam logic [7:0] ADDR_MASTER_ONE = 8'h01;
   localparam logic [7:0] ADDR_MASTER_TWO = 8'h02;
   localparam logic [7:0] ADDR_PLL_EN = 8'h03;
   localparam logic [7:0] ADDR_IN_EN = 8'h04;
   localparam logic [7:0] ADDR_OUT_EN_LO = 8'h05;
   localparam logic [7:0] ADDR_OUT_EN_HI = 8'h06;
   localparam logic [7:0] ADDR_MUX_ABC = 8'h07;
   localparam logic [7:0] ADDR_MUX_DEF = 8'h08;
   localparam logic [7:0] ADDR_STOP_LO = 8'h09;
   localparam logic [7:0] ADDR_STOP_HI = 8'h0A;
   localparam logic [7:0] ADDR_PIN_CFG = 8'h0B;
   localparam logic [7:0] ADDR_PIN0_SS = 8'h0D;
   localparam logic [7:0] ADDR_PIN1_SS = 8'h0E;
   localparam logic [7:0] ADDR_PIN_LEVEL = 8'h4A;
   localparam logic [7:0] ADDR_BLK_STATUS = 8'h4B;

   // Reset value and writable-bit masks (reserved bits read zero)
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MASK_MASTER_ONE = 8'h20;
   localparam logic [7:0] MASK_MASTER_TWO = 8'h77;
   localparam logic [7:0] MASK_PLL_EN = 8'h03;
   localparam logic [7:0] MASK_IN_EN = 8'h07;
   localparam logic [7:0] MASK_OUT_EN_HI = 8'h03;
   localparam logic [7:0] MASK_MUX = 8'h3F;
   localparam logic [7:0] MASK_STOP_HI = 8'h03;

   // Field positions
   localparam int GLOBAL_STOP_POS = 5;
   localparam int IN1_MON_POS = 4;
   localparam int IN2_MON_POS = 5;
   localparam int IN3_MON_POS = 6;
   localparam int DOUBLER_POS = 2;
   localparam int XTAL_MODE_LSB = 0;
   localparam int PIN1_CFG_LSB = 4;
   localparam int PIN0_CFG_LSB = 0;
   localparam int EARLY_POS = 0;
   localparam int SETTLED_POS = 1;

   // Crystal pin mode codes
   localparam logic [1:0] XTAL_OFF = 2'h0;
   localparam logic [1:0] XTAL_DRIVER = 2'h1;
   localparam logic [1:0] XTAL_SINGLE = 2'h2;

   // Group source mux codes
   localparam logic [1:0] SRC_P1_INT = 2'h0;
   localparam logic [1:0] SRC_P1_FRAC = 2'h1;
   localparam logic [1:0] SRC_P2_INT = 2'h2;
   localparam logic [1:0] SRC_P2_FRAC = 2'h3;

   // Stop source code that hands control to the stop registers
   localparam logic [3:0] STOP_SRC_REG = 4'h1;

   // Pin function codes
   localparam logic [3:0] PIN_IN = 4'h0;
   localparam logic [3:0] PIN_IN_INV = 4'h1;
   localparam logic [3:0] PIN_OUT_LOW = 4'h2;
   localparam logic [3:0] PIN_OUT_HIGH = 4'h3;
   localparam logic [3:0] PIN_STAT = 4'h4;
   localparam logic [3:0] PIN_STAT_INV = 4'h5;
   localparam logic [3:0] PIN_STAT_LOW_Z = 4'h6;
   localparam logic [3:0] PIN_STAT_Z_LOW = 4'h7;

   // Crystal settle time before the doubler may start
   localparam int DOUBLER_WAIT_MS = 5;
   localparam int CLK_FREQ_KHZ = 200000;
   localparam int DOUBLER_WAIT_CYCLES = DOUBLER_WAIT_MS * CLK_FREQ_KHZ;
endpackage : clock_cfg_pkg

/* File: clock_global_config_regs.sv */
// Summary of operation
// - Monitor select bit picks PLL feedback reference
// - Doubler enable bit powers doubler up/down
// - Crystal pin mode decodes off/driver/single-ended
// - PLL enable: bit0 first, bit1 second
// - Input enable bits 0..2 for inputs 1..3
// - Output enable bits for ten outputs
// - Group mux code selects PLL and divider
// - Mux fields map to groups A to F
// - Fractional codes follow PLL bypass control bit
// - Stop bit stops output when source register
// - Internal stop is own bit OR global
// - Stop bits laid out for ten outputs
// - Pin config fields; pin levels readable back
// - Code 0000 input, 0001 inverted input
// - Status-select register chooses pin status bit
// - Codes 0010 to 0111 drive low/high/status; codes 1xxx act as input
// - Global stop hits register-sourced outputs only
module clock_global_config_regs
   import clock_cfg_pkg::*;
#(
   parameter int WAIT_CYCLES = DOUBLER_WAIT_CYCLES
)(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_WDATA_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic [1:0] PLL_BYPASS_I,
   input wire logic [39:0] STOP_SRC_SEL_I,
   input wire logic [255:0] STATUS_VEC_I,
   input wire logic [1:0] GPIO_I,
   output logic [1:0] GPIO_O,
   output logic [1:0] GPIO_OE_O,
   output logic [2:0] IN_MON_REF_SEL_O,
   output logic DOUBLER_EN_O,
   output logic XTAL_DRV_EN_O,
   output logic XA_SE_IN_EN_O,
   output logic XTAL_SETTLED_O,
   output logic PLL_ONE_EN_O,
   output logic PLL_TWO_EN_O,
   output logic [2:0] INPUT_EN_O,
   output logic [9:0] OUT_EN_O,
   output logic [5:0] GROUP_SRC_PLL2_O,
   output logic [5:0] GROUP_SRC_FRAC_O,
   output logic [5:0] GROUP_SRC_BYPASS_O,
   output logic [9:0] OUT_STOP_O
);
   // Whole register state of the bank
   typedef struct packed {
      logic [7:0] master_one; // Global stop bit
      logic [7:0] master_two; // Monitor selects, doubler, crystal mode
      logic [7:0] pll_en; // PLL enables
      logic [7:0] in_en; // Input enables
      logic [7:0] oen_lo; // Outputs 1..8 enables
      logic [7:0] oen_hi; // Outputs 9..10 enables
      logic [7:0] mux_abc; // Groups A..C sources
      logic [7:0] mux_def; // Groups D..F sources
      logic [7:0] stop_lo; // Outputs 1..8 stop bits
      logic [7:0] stop_hi; // Outputs 9..10 stop bits
      logic [7:0] pin_cfg; // Pin function fields
      logic [7:0] ss0; // Pin 0 status select
      logic [7:0] ss1; // Pin 1 status select
      logic [7:0] rdata; // Read data
      logic [1:0] pin_meta; // First sync stage
      logic [1:0] pin_sync; // Second sync stage
      logic [19:0] settle_cnt; // Crystal settle counter
      logic early; // Doubler enabled before settle, sticky
      logic [5:0] grp_pll2; // Group uses second PLL
      logic [5:0] grp_frac; // Group uses fractional-or-bypass path
      logic [5:0] grp_byp; // That path is the bypass
      logic [9:0] out_stop; // Internal stop per output
   } bank_s;

   bank_s st_reg;
   bank_s st_next;
   logic [1:0] pin_level; // Reported pin levels
   logic [1:0] pin_status; // Selected status bit per pin
   logic [9:0] stop_bits; // Ten stop bits in order
   logic [1:0] xtal_mode; // Crystal pin mode field
   logic settled; // Crystal settle time elapsed

   // Decode one group mux field into pll2, frac, bypass
   function automatic logic [2:0] src_decode(input logic [1:0] code,
                                             input logic [1:0] byp);
      logic two;
      logic frac;
      two = code[1];
      frac = code[0];
      return {two, frac, frac & byp[two]};
   endfunction : src_decode

   // Internal stop for one output
   function automatic logic stop_calc(input logic [3:0] src,
                                      input logic own,
                                      input logic glob);
      return (src == STOP_SRC_REG) && (own || glob);
   endfunction : stop_calc

   // Masked register write value
   function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
      return d & m;
   endfunction : masked

   assign stop_bits = {st_reg.stop_hi[1:0], st_reg.stop_lo};
   assign xtal_mode = st_reg.master_two[XTAL_MODE_LSB +: 2];
   assign settled = (st_reg.settle_cnt >= 20'(WAIT_CYCLES));

   // Status bit per pin from its select register
   assign pin_status[0] = STATUS_VEC_I[st_reg.ss0];
   assign pin_status[1] = STATUS_VEC_I[st_reg.ss1];

   // Next state: writes, reads, sync, derived outputs
   always_comb begin
      logic [2:0] dec;
      dec = 3'h0;
      st_next = st_reg;
      // Pin synchroniser, second stage reads only the first
      st_next.pin_meta = GPIO_I;
      st_next.pin_sync = st_reg.pin_meta;
      // Settle counter runs while the crystal input is active
      if (xtal_mode == XTAL_DRIVER || xtal_mode == XTAL_SINGLE) begin
         if (!settled) begin
            st_next.settle_cnt = st_reg.settle_cnt + 20'h00001;
         end
      end else begin
         st_next.settle_cnt = 20'h00000;
      end
      // Register writes
      if (REG_WR_I) begin
         unique case (REG_ADDR_I)
            ADDR_MASTER_ONE: st_next.master_one = masked(REG_WDATA_I, MASK_MASTER_ONE);
            ADDR_MASTER_TWO: st_next.master_two = masked(REG_WDATA_I, MASK_MASTER_TWO);
            ADDR_PLL_EN: st_next.pll_en = masked(REG_WDATA_I, MASK_PLL_EN);
            ADDR_IN_EN: st_next.in_en = masked(REG_WDATA_I, MASK_IN_EN);
            ADDR_OUT_EN_LO: st_next.oen_lo = REG_WDATA_I;
            ADDR_OUT_EN_HI: st_next.oen_hi = masked(REG_WDATA_I, MASK_OUT_EN_HI);
            ADDR_MUX_ABC: st_next.mux_abc = masked(REG_WDATA_I, MASK_MUX);
            ADDR_MUX_DEF: st_next.mux_def = masked(REG_WDATA_I, MASK_MUX);
            ADDR_STOP_LO: st_next.stop_lo = REG_WDATA_I;
            ADDR_STOP_HI: st_next.stop_hi = masked(REG_WDATA_I, MASK_STOP_HI);
            ADDR_PIN_CFG: st_next.pin_cfg = REG_WDATA_I;
            ADDR_PIN0_SS: st_next.ss0 = REG_WDATA_I;
            ADDR_PIN1_SS: st_next.ss1 = REG_WDATA_I;
            ADDR_BLK_STATUS: begin
               // Write one clears the early flag
               if (REG_WDATA_I[EARLY_POS]) begin
                  st_next.early = 1'b0;
               end
            end
            default: ; // Unmapped or read-only address ignored
         endcase
      end
      // Doubler switched on before settle; set wins over clear
      if (st_reg.master_two[DOUBLER_POS] && !settled) begin
         st_next.early = 1'b1;
      end
      // Register reads
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            ADDR_MASTER_ONE: st_next.rdata = st_reg.master_one;
            ADDR_MASTER_TWO: st_next.rdata = st_reg.master_two;
            ADDR_PLL_EN: st_next.rdata = st_reg.pll_en;
            ADDR_IN_EN: st_next.rdata = st_reg.in_en;
            ADDR_OUT_EN_LO: st_next.rdata = st_reg.oen_lo;
            ADDR_OUT_EN_HI: st_next.rdata = st_reg.oen_hi;
            ADDR_MUX_ABC: st_next.rdata = st_reg.mux_abc;
            ADDR_MUX_DEF: st_next.rdata = st_reg.mux_def;
            ADDR_STOP_LO: st_next.rdata = st_reg.stop_lo;
            ADDR_STOP_HI: st_next.rdata = st_reg.stop_hi;
            ADDR_PIN_CFG: st_next.rdata = st_reg.pin_cfg;
            ADDR_PIN0_SS: st_next.rdata = st_reg.ss0;
            ADDR_PIN1_SS: st_next.rdata = st_reg.ss1;
            ADDR_PIN_LEVEL: st_next.rdata = {6'h00, pin_level};
            ADDR_BLK_STATUS: st_next.rdata = {6'h00, settled, st_reg.early};
            default: st_next.rdata = 8'h00; // Unmapped reads zero
         endcase
      end
      // Group sources: A,B,C from first register, D,E,F from second
      for (int g = 0; g < 6; g++) begin
         dec = src_decode(g < 3 ? st_reg.mux_abc[2*(g%3) +: 2]
                                : st_reg.mux_def[2*(g%3) +: 2], PLL_BYPASS_I);
         st_next.grp_pll2[g] = dec[2];
         st_next.grp_frac[g] = dec[1];
         st_next.grp_byp[g] = dec[0];
      end
      // Internal stop per output
      for (int k = 0; k < 10; k++) begin
         st_next.out_stop[k] = stop_calc(STOP_SRC_SEL_I[4*k +: 4], stop_bits[k],
                                         st_reg.master_one[GLOBAL_STOP_POS]);
      end
   end

   // State register
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // One pin controller per pin
   for (genvar p = 0; p < 2; p++) begin : g_pin
      pin_function_ctrl u_pin (
         .clk_i(CLK_I),
         .rst_i(RST_I),
         .cfg_i(p == 0 ? st_reg.pin_cfg[PIN0_CFG_LSB +: 4]
                       : st_reg.pin_cfg[PIN1_CFG_LSB +: 4]),
         .level_i(st_reg.pin_sync[p]),
         .status_i(pin_status[p]),
         .pin_o(GPIO_O[p]),
         .pin_oe_o(GPIO_OE_O[p]),
         .level_o(pin_level[p])
      );
   end

   // Outputs straight from register bits
   assign REG_RDATA_O = st_reg.rdata;
   assign IN_MON_REF_SEL_O = {st_reg.master_two[IN3_MON_POS],
                              st_reg.master_two[IN2_MON_POS],
                              st_reg.master_two[IN1_MON_POS]};
   assign DOUBLER_EN_O = st_reg.master_two[DOUBLER_POS];
   assign XTAL_DRV_EN_O = (xtal_mode == XTAL_DRIVER);
   assign XA_SE_IN_EN_O = (xtal_mode == XTAL_SINGLE);
   assign XTAL_SETTLED_O = settled;
   assign PLL_ONE_EN_O = st_reg.pll_en[0];
   assign PLL_TWO_EN_O = st_reg.pll_en[1];
   assign INPUT_EN_O = st_reg.in_en[2:0];
   assign OUT_EN_O = {st_reg.oen_hi[1:0], st_reg.oen_lo};
   assign GROUP_SRC_PLL2_O = st_reg.grp_pll2;
   assign GROUP_SRC_FRAC_O = st_reg.grp_frac;
   assign GROUP_SRC_BYPASS_O = st_reg.grp_byp;
   assign OUT_STOP_O = st_reg.out_stop;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   a_pll_enable_map: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_PLL_EN)
      |=> (PLL_ONE_EN_O == $past(REG_WDATA_I[0]) && PLL_TWO_EN_O == $past(REG_WDATA_I[1])))
      else $error("pll enable not taken");
   a_input_enable_map: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_IN_EN) |=> (INPUT_EN_O == $past(REG_WDATA_I[2:0])))
      else $error("input enable not taken");
   a_out_enable_hi: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_OUT_EN_HI) |=> (OUT_EN_O[9:8] == $past(REG_WDATA_I[1:0])))
      else $error("output 9-10 enable not taken");
   a_monitor_ref_sel: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_MASTER_TWO)
      |=> (IN_MON_REF_SEL_O == {$past(REG_WDATA_I[6]), $past(REG_WDATA_I[5:4])}))
      else $error("monitor reference select wrong");
   a_xtal_unused_off: assert property (
      (xtal_mode == 2'h3) |-> (!XTAL_DRV_EN_O && !XA_SE_IN_EN_O))
      else $error("unused crystal mode powers pins");
   a_group_a_source: assert property (
      (st_reg.mux_abc[1:0] == SRC_P2_FRAC && PLL_BYPASS_I[1])
      |=> (GROUP_SRC_PLL2_O[0] && GROUP_SRC_FRAC_O[0] && GROUP_SRC_BYPASS_O[0]))
      else $error("group A source wrong");
   a_group_f_source: assert property (
      (st_reg.mux_def[5:4] == SRC_P1_INT) |=> (!GROUP_SRC_PLL2_O[5] && !GROUP_SRC_FRAC_O[5]))
      else $error("group F source wrong");
   a_global_stop_or: assert property (
      (st_reg.master_one[GLOBAL_STOP_POS] && STOP_SRC_SEL_I[39:36] == STOP_SRC_REG)
      |=> OUT_STOP_O[9])
      else $error("global stop not applied");
   a_stop_src_gate: assert property (
      (STOP_SRC_SEL_I[3:0] != STOP_SRC_REG) |=> !OUT_STOP_O[0])
      else $error("stop applied to non-register source");
   a_early_sticky: assert property (
      (st_reg.early && !(REG_WR_I && REG_ADDR_I == ADDR_BLK_STATUS)) |=> st_reg.early)
      else $error("early flag lost");
   // Register writes reach their outputs one edge later
   a_doubler_bit: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_MASTER_TWO)
      |=> (DOUBLER_EN_O == $past(REG_WDATA_I[DOUBLER_POS])))
      else $error("doubler enable not taken");
   a_xtal_single_mode: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_MASTER_TWO && REG_WDATA_I[XTAL_MODE_LSB +: 2] == XTAL_SINGLE)
      |=> (XA_SE_IN_EN_O && !XTAL_DRV_EN_O))
      else $error("single-ended crystal mode wrong");
   a_out_enable_lo: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_OUT_EN_LO) |=> (OUT_EN_O[7:0] == $past(REG_WDATA_I)))
      else $error("output 1-8 enable not taken");
   // Derived outputs follow their causes one edge later
   a_stop_own_bit: assert property (
      (stop_bits[0] && STOP_SRC_SEL_I[3:0] == STOP_SRC_REG) |=> OUT_STOP_O[0])
      else $error("own stop bit not applied");
   a_group_c_bypass: assert property (
      (st_reg.mux_abc[5:4] == SRC_P1_FRAC)
      |=> (GROUP_SRC_FRAC_O[2] && GROUP_SRC_BYPASS_O[2] == $past(PLL_BYPASS_I[0])))
      else $error("group C bypass choice wrong");
   // Clearing the early flag works when no new cause is present
   a_early_clear: assert property (
      (REG_WR_I && REG_ADDR_I == ADDR_BLK_STATUS && REG_WDATA_I[EARLY_POS]
       && !(DOUBLER_EN_O && !XTAL_SETTLED_O)) |=> !st_reg.early)
      else $error("early flag not cleared");
endmodule : clock_global_config_regs

/* File: clock_global_config_regs_tb.sv */
// Compare one design value with its expected value, report at once
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
   $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end

module clock_global_config_regs_tb
   import clock_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SIM_WAIT = 20; // Short crystal settle count
   logic CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic [7:0] REG_ADDR_I = 8'h00;
   logic REG_WR_I = 1'b0;
   logic REG_RD_I = 1'b0;
   logic [7:0] REG_WDATA_I = 8'h00;
   logic [1:0] PLL_BYPASS_I = 2'h0;
   logic [39:0] STOP_SRC_SEL_I = 40'h0;
   logic [255:0] STATUS_VEC_I = 256'h0;
   logic [1:0] gpio_ext = 2'h3; // Level of the far side of each pin
   wire logic [1:0] GPIO_I;
   logic [7:0] REG_RDATA_O;
   logic [1:0] GPIO_O;
   logic [1:0] GPIO_OE_O;
   logic [2:0] IN_MON_REF_SEL_O;
   logic DOUBLER_EN_O;
   logic XTAL_DRV_EN_O;
   logic XA_SE_IN_EN_O;
   logic XTAL_SETTLED_O;
   logic PLL_ONE_EN_O;
   logic PLL_TWO_EN_O;
   logic [2:0] INPUT_EN_O;
   logic [9:0] OUT_EN_O;
   logic [5:0] GROUP_SRC_PLL2_O;
   logic [5:0] GROUP_SRC_FRAC_O;
   logic [5:0] GROUP_SRC_BYPASS_O;
   logic [9:0] OUT_STOP_O;
   int fails = 0; // Mismatch count
   int tests_run = 0; // Comparison count
   int cycles = 0; // Hang guard

   // Pin wire level: the design wins while it drives
   assign GPIO_I[0] = GPIO_OE_O[0] ? GPIO_O[0] : gpio_ext[0];
   assign GPIO_I[1] = GPIO_OE_O[1] ? GPIO_O[1] : gpio_ext[1];

   clock_global_config_regs #(.WAIT_CYCLES(SIM_WAIT)) uut (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .REG_ADDR_I(REG_ADDR_I),
      .REG_WR_I(REG_WR_I),
      .REG_RD_I(REG_RD_I),
      .REG_WDATA_I(REG_WDATA_I),
      .REG_RDATA_O(REG_RDATA_O),
      .PLL_BYPASS_I(PLL_BYPASS_I),
      .STOP_SRC_SEL_I(STOP_SRC_SEL_I),
      .STATUS_VEC_I(STATUS_VEC_I),
      .GPIO_I(GPIO_I),
      .GPIO_O(GPIO_O),
      .GPIO_OE_O(GPIO_OE_O),
      .IN_MON_REF_SEL_O(IN_MON_REF_SEL_O),
      .DOUBLER_EN_O(DOUBLER_EN_O),
      .XTAL_DRV_EN_O(XTAL_DRV_EN_O),
      .XA_SE_IN_EN_O(XA_SE_IN_EN_O),
      .XTAL_SETTLED_O(XTAL_SETTLED_O),
      .PLL_ONE_EN_O(PLL_ONE_EN_O),
      .PLL_TWO_EN_O(PLL_TWO_EN_O),
      .INPUT_EN_O(INPUT_EN_O),
      .OUT_EN_O(OUT_EN_O),
      .GROUP_SRC_PLL2_O(GROUP_SRC_PLL2_O),
      .GROUP_SRC_FRAC_O(GROUP_SRC_FRAC_O),
      .GROUP_SRC_BYPASS_O(GROUP_SRC_BYPASS_O),
      .OUT_STOP_O(OUT_STOP_O)
   );

   // Free-running 200 MHz clock
   always #2.5 CLK_I = ~CLK_I;

   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // Cut a hang short
   always @(posedge CLK_I) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   // One-cycle write strobe, then let derived outputs land
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge CLK_I);
      REG_ADDR_I = a;
      REG_WDATA_I = d;
      REG_WR_I = 1'b1;
      @(negedge CLK_I);
      REG_WR_I = 1'b0;
      repeat (2) @(negedge CLK_I);
   endtask : wr

   // One-cycle read strobe, data taken after the edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge CLK_I);
      REG_ADDR_I = a;
      REG_RD_I = 1'b1;
      @(negedge CLK_I);
      REG_RD_I = 1'b0;
      d = REG_RDATA_O;
   endtask : rd

   // Read and compare
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      `CHK(d, e);
   endtask : chk_rd

   // End-of-test line
   task automatic end_test(input string name);
      $display("test %s finished", name);
   endtask : end_test

   // Main sequence
   initial begin
      logic [7:0] d;
      logic [1:0] c;
      logic wire_lvl;
      logic [7:0] addrs [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
         8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E};
      logic [7:0] masks [13] = '{8'h20, 8'h77, 8'h03, 8'h07, 8'hFF, 8'h03, 8'h3F,
         8'h3F, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF};
      logic [1:0] pin_exp [9] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 2'h2, 2'h0, 2'h2, 2'h0};
      repeat (12) @(posedge CLK_I);
      @(negedge CLK_I);
      RST_I = 1'b0;
      // Reset values and writable bits of every read-write register
      for (int i = 0; i < 13; i++) begin
         chk_rd(addrs[i], REG_RESET);
         wr(addrs[i], 8'hFF);
         chk_rd(addrs[i], masks[i]);
         wr(addrs[i], 8'h00);
      end
      wr(8'h20, 8'hFF);
      chk_rd(8'h20, 8'h00);
      end_test("registers");
      // Enables for outputs 1, 3, 4, 6, 8 and 9 across both enable registers first
      wr(ADDR_OUT_EN_LO, 8'hAD);
      wr(ADDR_OUT_EN_HI, 8'h01);
      `CHK(OUT_EN_O, 10'h1AD);
      // Enable bit positions
      wr(ADDR_PLL_EN, 8'h01);
      `CHK({PLL_TWO_EN_O, PLL_ONE_EN_O}, 2'b01);
      wr(ADDR_PLL_EN, 8'h02);
      `CHK({PLL_TWO_EN_O, PLL_ONE_EN_O}, 2'b10);
      wr(ADDR_IN_EN, 8'h05);
      `CHK(INPUT_EN_O, 3'b101);
      wr(ADDR_IN_EN, 8'h02);
      `CHK(INPUT_EN_O, 3'b010);
      wr(ADDR_OUT_EN_LO, 8'h81);
      wr(ADDR_OUT_EN_HI, 8'h02);
      `CHK(OUT_EN_O, 10'h281);
      end_test("enables");
      // Monitor reference selects, doubler, crystal modes and settle flags
      wr(ADDR_MASTER_TWO, 8'h50);
      `CHK(IN_MON_REF_SEL_O, 3'b101);
      wr(ADDR_MASTER_TWO, 8'h20);
      `CHK(IN_MON_REF_SEL_O, 3'b010);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_MASTER_TWO, 8'h04 | 8'(m));
         `CHK(DOUBLER_EN_O, 1'b1);
         `CHK(XTAL_DRV_EN_O, m == 1);
         `CHK(XA_SE_IN_EN_O, m == 2);
      end
      wr(ADDR_MASTER_TWO, 8'h00);
      `CHK(DOUBLER_EN_O, 1'b0);
      wr(ADDR_MASTER_TWO, 8'h01);
      repeat (12) @(negedge CLK_I);
      `CHK(XTAL_SETTLED_O, 1'b0);
      repeat (10) @(negedge CLK_I);
      `CHK(XTAL_SETTLED_O, 1'b1);
      rd(ADDR_BLK_STATUS, d);
      `CHK(d[SETTLED_POS], 1'b1);
      `CHK(d[EARLY_POS], 1'b1);
      // Clear the early flag, then start the doubler only once settled
      wr(ADDR_BLK_STATUS, 8'h01);
      wr(ADDR_MASTER_TWO, 8'h05);
      `CHK(DOUBLER_EN_O, 1'b1);
      rd(ADDR_BLK_STATUS, d);
      `CHK(d, 8'h02);
      wr(ADDR_MASTER_TWO, 8'h03);
      `CHK(XTAL_SETTLED_O, 1'b0);
      end_test("master");
      // Group source codes, then field-to-group mapping
      PLL_BYPASS_I = 2'b10;
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         wr(ADDR_MUX_ABC, {2'b00, c, c, c});
         wr(ADDR_MUX_DEF, {2'b00, c, c, c});
         `CHK(GROUP_SRC_PLL2_O, {6{c[1]}});
         `CHK(GROUP_SRC_FRAC_O, {6{c[0]}});
         `CHK(GROUP_SRC_BYPASS_O, {6{c[0] & c[1]}});
      end
      wr(ADDR_MUX_ABC, 8'h24);
      wr(ADDR_MUX_DEF, 8'h1B);
      `CHK(GROUP_SRC_PLL2_O, 6'b011100);
      `CHK(GROUP_SRC_FRAC_O, 6'b101010);
      `CHK(GROUP_SRC_BYPASS_O, 6'b001000);
      PLL_BYPASS_I = 2'b01;
      repeat (3) @(negedge CLK_I);
      `CHK(GROUP_SRC_BYPASS_O, 6'b100010);
      end_test("mux");
      // Per-output and global stop, output ten not register sourced
      STOP_SRC_SEL_I = {4'h0, {9{STOP_SRC_REG}}};
      wr(ADDR_STOP_LO, 8'hA5);
      wr(ADDR_STOP_HI, 8'h03);
      `CHK(OUT_STOP_O, 10'h1A5);
      wr(ADDR_MASTER_ONE, 8'h20);
      `CHK(OUT_STOP_O, 10'h1FF);
      wr(ADDR_STOP_LO, 8'h00);
      wr(ADDR_STOP_HI, 8'h00);
      `CHK(OUT_STOP_O, 10'h1FF);
      // Output ten handed to the registers: global stop alone stops it
      STOP_SRC_SEL_I[39:36] = STOP_SRC_REG;
      repeat (2) @(negedge CLK_I);
      `CHK(OUT_STOP_O, 10'h3FF);
      STOP_SRC_SEL_I[39:36] = 4'h0;
      wr(ADDR_MASTER_ONE, 8'h00);
      `CHK(OUT_STOP_O, 10'h000);
      end_test("stop");
      // Every pin function code on pin 0, status bit 5 high
      STATUS_VEC_I[5] = 1'b1;
      wr(ADDR_PIN0_SS, 8'h05);
      for (int k = 0; k < 9; k++) begin
         wr(ADDR_PIN_CFG, 8'(k));
         `CHK({GPIO_OE_O[0], GPIO_O[0]}, pin_exp[k]);
         repeat (4) @(negedge CLK_I);
         rd(ADDR_PIN_LEVEL, d);
         wire_lvl = pin_exp[k][1] ? pin_exp[k][0] : gpio_ext[0];
         `CHK(d[0], (k == 1) ? ~wire_lvl : wire_lvl);
         `CHK(d[1], gpio_ext[1]);
      end
      // Pin 1 follows its own selected status bit
      wr(ADDR_PIN1_SS, 8'h05);
      wr(ADDR_PIN_CFG, 8'h40);
      `CHK({GPIO_OE_O[1], GPIO_O[1]}, 2'b11);
      STATUS_VEC_I[5] = 1'b0;
      repeat (3) @(negedge CLK_I);
      `CHK({GPIO_OE_O[1], GPIO_O[1]}, 2'b10);
      end_test("pins");
      summarize();
   end
endmodule : clock_global_config_regs_tb

/* File: pin_function_ctrl.sv */
module pin_function_ctrl
   import clock_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] cfg_i,
   input wire logic level_i,
   input wire logic status_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic level_o
);
   // Registered pin drive and reported level
   typedef struct packed {
      logic drive;
      logic oe;
      logic level;
   } pin_s;

   pin_s st_reg;
   pin_s st_next;

   // Decode the pin function code
   always_comb begin
      st_next = st_reg;
      st_next.drive = 1'b0;
      st_next.oe = 1'b0;
      st_next.level = level_i;
      unique case (cfg_i)
         PIN_IN_INV: st_next.level = ~level_i;
         PIN_OUT_LOW: st_next.oe = 1'b1;
         PIN_OUT_HIGH: begin
            st_next.drive = 1'b1;
            st_next.oe = 1'b1;
         end
         PIN_STAT: begin
            st_next.drive = status_i;
            st_next.oe = 1'b1;
         end
         PIN_STAT_INV: begin
            st_next.drive = ~status_i;
            st_next.oe = 1'b1;
         end
         PIN_STAT_LOW_Z: st_next.oe = ~status_i;
         PIN_STAT_Z_LOW: st_next.oe = status_i;
         default: ; // Plain input, also for unused codes
      endcase
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_o = st_reg.drive;
   assign pin_oe_o = st_reg.oe;
   assign level_o = st_reg.level;

   a_pin_drive_high: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg_i == PIN_OUT_HIGH) |=> (pin_o && pin_oe_o))
      else $error("pin not driven high");
   a_pin_input_inv: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg_i == PIN_IN_INV) |=> (!pin_oe_o && (level_o == !$past(level_i))))
      else $error("inverted input level wrong");
endmodule : pin_function_ctrl
